// ### oag_pkg.sv
package oag_pkg;

   // ==========================================
   // Instruction word fields
   localparam int MODE_BIT      = 7;
   localparam int IDX_BIT       = 6;
   localparam int INC_BIT       = 5;
   localparam int DEC_BIT       = 4;
   localparam int RELOAD_BIT    = 3;
   localparam int SHIFT_LSB     = 8;
   localparam int WORD_W        = 16;
   localparam int PTR_W         = 3;
   localparam int PAGE_W        = 9;
   localparam int SHORT_W       = 8;
   localparam int MPY_W         = 13;
   localparam int DMA_W         = 7;
   localparam int CMPMODE_W     = 2;
   localparam int NUM_AR        = 8;

   // ==========================================
   // Reset values
   localparam logic [2:0]  PTR_RST  = 3'h0;
   localparam logic [8:0]  PAGE_RST = 9'h000;
   localparam logic [15:0] AR_RST   = 16'h0000;
   localparam logic [7:0]  RPT_RST  = 8'h00;

   // ==========================================
   // Opcode patterns (upper byte unless noted)
   localparam logic [7:0] OP_ADDK  = 8'hcc;
   localparam logic [7:0] OP_SUBK  = 8'hcd;
   localparam logic [7:0] OP_LACK  = 8'hca;
   localparam logic [7:0] OP_RPT    = 8'hcb;
   localparam logic [7:0] OP_AUXADD = 8'h7e;
   localparam logic [7:0] OP_AUXSUB = 8'h7f;
   localparam logic [7:0] OP_MAR   = 8'h55;
   localparam logic [4:0] OP_LARK5 = 5'h18;
   localparam logic [6:0] OP_PAGE7 = 7'h64;
   localparam logic [2:0] OP_MPY3  = 3'h5;
   localparam logic [3:0] OP_LONG4 = 4'hd;
   localparam logic [12:0] OP_PTR13 = 13'h0ab1;
   localparam logic [13:0] OP_AUXCMP14 = 14'h3394;
   localparam logic [11:0] LONG_LRLK = 12'h000;
   localparam logic [11:0] LONG_LALK = 12'h001;

   // Update operation codes from bits 6..4
   typedef enum logic [2:0] {
      UPD_NONE  = 3'b000,
      UPD_DEC   = 3'b001,
      UPD_INC   = 3'b010,
      UPD_RSVD  = 3'b011,
      UPD_RSUB  = 3'b100,
      UPD_XSUB  = 3'b101,
      UPD_XADD  = 3'b110,
      UPD_RADD  = 3'b111
   } upd_t;

   typedef enum logic [1:0] {
      CMP_EQ = 2'b00,
      CMP_LT = 2'b01,
      CMP_GT = 2'b10,
      CMP_NE = 2'b11
   } cmp_t;

endpackage

// ### aux_bus_if.sv
interface aux_bus_if #(parameter int W = 16);
   logic [W-1:0] cur;
   logic [W-1:0] idx;
   logic [2:0]   op;
   logic [W-1:0] result;
   modport core (output cur, output idx, output op, input result);
   modport unit (input cur, input idx, input op, output result);
endinterface

// ### aux_arith_unit.sv
module aux_arith_unit
   import oag_pkg::*;
#(
   parameter int W = 16
) (
   aux_bus_if.unit bus
);

   // ==========================================
   // Bit reversal helpers
   function automatic logic [W-1:0] rev(input logic [W-1:0] v);
      logic [W-1:0] r;
      r = '0;
      for (int i = 0; i < W; i++) begin
         r[i] = v[W-1-i];
      end
      return r;
   endfunction

   // Reverse carry: reverse, add or subtract normally, reverse back
   wire [W-1:0] rc_add = rev(rev(bus.cur) + rev(bus.idx));    // [RULE16]
   wire [W-1:0] rc_sub = rev(rev(bus.cur) - rev(bus.idx));    // [RULE16]
   wire [W-1:0] one    = {{(W-1){1'b0}}, 1'b1};

   always_comb begin
      case (upd_t'(bus.op))
         UPD_NONE: bus.result = bus.cur;                      // [RULE1]
         UPD_DEC:  bus.result = bus.cur - one;                // [RULE1]
         UPD_INC:  bus.result = bus.cur + one;                // [RULE1]
         UPD_RSVD: bus.result = bus.cur;                      // [RULE17]
         UPD_XSUB: bus.result = bus.cur - bus.idx;            // [RULE2]
         UPD_XADD: bus.result = bus.cur + bus.idx;            // [RULE2]
         UPD_RSUB: bus.result = rc_sub;                       // [RULE3]
         UPD_RADD: bus.result = rc_add;                       // [RULE3]
         default:  bus.result = bus.cur;
      endcase
   end

endmodule // aux_arith_unit

// ### operand_address_generator.sv
// How it works
// RULE1: Step-by-one code keeps, increments or decrements
// RULE2: Index bit adds or subtracts index register
// RULE3: Bit-reversed codes use reverse carry
// RULE4: Bit 3 set loads pointer from bits 2-0
// RULE5: Pointer reload applies to later instructions
// RULE6: Compare with index register sets test flag
// RULE7: Short constants are 8-bit, one cycle
// RULE8: Pointer constant 3-bit, page constant 9-bit
// RULE9: Multiply constant is 13-bit signed
// RULE10: Repeat count low byte, runs count+1 times
// RULE11: Long constant is next 16-bit word
// RULE12: Long constant shifted by bits 11-8
// RULE13: Register field 3-bit, compare mode 2-bit
// RULE14: Bit 7 selects indirect versus direct
// RULE15: Unsigned 16-bit update after address use
// RULE16: Reverse carry runs from MSB downward
// RULE17: Reserved code leaves register unchanged
module operand_address_generator
   import oag_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Instruction stream from fetch
   input  wire logic         instr_valid,
   input  wire logic [W-1:0] instr_word,
   input  wire logic         long_valid,
   input  wire logic [W-1:0] long_word,
   input  wire logic         long_signed,
   // Operand outputs
   output logic      [W-1:0] data_addr,
   output logic              addr_valid,
   output logic      [31:0]  imm_value,
   output logic              imm_valid,
   output logic      [7:0]   repeat_left,
   output logic              test_control_flag,
   output logic      [2:0]   aux_reg_pointer,
   output logic      [8:0]   data_page_pointer,
   output logic      [W-1:0] index_aux_reg
);

   // ==========================================
   // State
   logic [W-1:0] ar_reg [NUM_AR];
   logic [2:0]   ptr_reg;
   logic [8:0]   page_reg;
   logic         flag_reg;
   logic [7:0]   rpt_reg;
   logic [W-1:0] addr_reg;
   logic         addr_vld_reg;
   logic [31:0]  imm_reg;
   logic         imm_vld_reg;
   logic         long_pend_reg;
   logic [3:0]   long_shift_reg;
   logic         is_lrlk_reg;
   logic [2:0]   lrlk_sel_reg;

   // Every check below samples on the rising clock edge
   default clocking chk_clk @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ==========================================
   // Field decode
   wire [7:0] opc       = instr_word[15:8];
   wire       indirect  = instr_word[MODE_BIT];                // [RULE14]
   wire       index_select_bit   = instr_word[IDX_BIT];
   wire       pointer_reload_bit = instr_word[RELOAD_BIT];
   wire [2:0] next_ptr  = instr_word[2:0];
   wire [2:0] upd_code  = instr_word[IDX_BIT:DEC_BIT];
   wire [6:0] dma       = instr_word[DMA_W-1:0];
   wire [2:0] reg_sel   = instr_word[10:8];                    // [RULE13]
   wire [1:0] compare_mode_field = instr_word[CMPMODE_W-1:0];  // [RULE13]
   wire [7:0] k8        = instr_word[SHORT_W-1:0];             // [RULE7]
   wire [3:0] shift4    = instr_word[11:SHIFT_LSB];

   wire is_addk  = opc == OP_ADDK;
   wire is_subk  = opc == OP_SUBK;
   wire is_lack  = opc == OP_LACK;
   wire repeat_short_op   = opc == OP_RPT;
   wire aux_add_short_op  = opc == OP_AUXADD;
   wire aux_sub_short_op  = opc == OP_AUXSUB;
   wire is_lark  = instr_word[15:11] == OP_LARK5;
   wire page_load_short_op = instr_word[15:9] == OP_PAGE7;
   wire multiply_short_op  = instr_word[15:13] == OP_MPY3;
   wire pointer_load_op    = instr_word[15:3] == OP_PTR13;
   wire aux_compare_op     = instr_word[15:2] == OP_AUXCMP14;
   wire is_long  = instr_word[15:12] == OP_LONG4;
   wire is_lrlk  = is_long && instr_word[11] == 1'b0
                   && instr_word[7:0] == 8'h00;

   wire short_k = is_addk | is_subk | is_lack | repeat_short_op
                  | aux_add_short_op | aux_sub_short_op | is_lark
                  | page_load_short_op | multiply_short_op
                  | pointer_load_op | aux_compare_op;
   // Memory-reference forms are everything not immediate, long or in the 0xc opcode group
   wire mem_ref  = !short_k && !is_long && instr_word[15:12] != 4'hc;

   // ==========================================
   // Auxiliary arithmetic
   aux_bus_if #(.W(W)) abus ();
   wire [W-1:0] cur_ar = ar_reg[ptr_reg];
   assign abus.cur = cur_ar;
   assign abus.idx = ar_reg[0];
   assign abus.op  = (mem_ref && indirect) ? upd_code : UPD_NONE;
   aux_arith_unit #(.W(W)) u_alu (.bus(abus));

   wire [W-1:0] k8_ext = {{(W-8){1'b0}}, k8};
   wire [W-1:0] short_upd = aux_add_short_op ? cur_ar + k8_ext
                                             : cur_ar - k8_ext;

   // Compare modes, unsigned 16-bit
   logic cmp_res;
   always_comb begin
      case (cmp_t'(compare_mode_field))
         CMP_EQ:  cmp_res = cur_ar == ar_reg[0];               // [RULE6]
         CMP_LT:  cmp_res = cur_ar <  ar_reg[0];
         CMP_GT:  cmp_res = cur_ar >  ar_reg[0];
         CMP_NE:  cmp_res = cur_ar != ar_reg[0];
         default: cmp_res = 1'b0;
      endcase
   end

   // Immediate selection
   wire [31:0] imm_short = {24'h000000, k8};                   // [RULE7]
   wire [31:0] imm_mpy   = {{19{instr_word[12]}},
                            instr_word[MPY_W-1:0]};            // [RULE9]
   wire [31:0] imm_page  = {23'h0, instr_word[PAGE_W-1:0]};    // [RULE8]
   wire [31:0] imm_ptr   = {29'h0, instr_word[2:0]};           // [RULE8]
   wire [31:0] long_ext  = long_signed ? {{16{long_word[15]}}, long_word}
                                       : {16'h0000, long_word}; // [RULE11]
   wire [31:0] long_sh   = long_ext << long_shift_reg;         // [RULE12]

   wire [31:0] imm_sel = multiply_short_op  ? imm_mpy  :
                         page_load_short_op ? imm_page :
                         pointer_load_op    ? imm_ptr  : imm_short;

   wire take  = instr_valid && !long_pend_reg;
   wire [W-1:0] addr_sel = indirect ? cur_ar : {page_reg, dma};

   // ==========================================
   // Auxiliary registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_AR; i++) begin
            ar_reg[i] <= AR_RST;
         end
      end else if (take) begin
         if (is_lark) begin
            ar_reg[reg_sel] <= k8_ext;
         end else if (aux_add_short_op || aux_sub_short_op) begin
            ar_reg[ptr_reg] <= short_upd;
         end else if (mem_ref && indirect) begin
            ar_reg[ptr_reg] <= abus.result;                    // [RULE15]
         end
      end else if (long_pend_reg && long_valid && is_lrlk_reg) begin
         ar_reg[lrlk_sel_reg] <= long_word;
      end
   end

   // ==========================================
   // Pointer, page, flag, repeat, outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ptr_reg       <= PTR_RST;
         page_reg      <= PAGE_RST;
         flag_reg      <= 1'b0;
         rpt_reg       <= RPT_RST;
         addr_reg      <= AR_RST;
         addr_vld_reg  <= 1'b0;
         imm_reg       <= 32'h00000000;
         imm_vld_reg   <= 1'b0;
         long_pend_reg <= 1'b0;
         long_shift_reg <= 4'h0;
         is_lrlk_reg   <= 1'b0;
         lrlk_sel_reg  <= 3'h0;
      end else begin
         addr_vld_reg <= 1'b0;
         imm_vld_reg  <= 1'b0;
         if (take) begin
            if (mem_ref) begin
               addr_reg     <= addr_sel;                       // [RULE15]
               addr_vld_reg <= 1'b1;
               if (indirect && pointer_reload_bit) begin
                  ptr_reg <= next_ptr;                         // [RULE4] [RULE5]
               end
            end
            if (short_k) begin
               imm_reg     <= imm_sel;                         // [RULE7]
               imm_vld_reg <= 1'b1;
            end
            if (pointer_load_op) begin
               ptr_reg <= next_ptr;                            // [RULE8]
            end
            if (page_load_short_op) begin
               page_reg <= instr_word[PAGE_W-1:0];             // [RULE8]
            end
            if (aux_compare_op) begin
               flag_reg <= cmp_res;                            // [RULE6]
            end
            if (repeat_short_op) begin
               rpt_reg <= k8;                                  // [RULE10]
            end else if (rpt_reg != RPT_RST) begin
               rpt_reg <= rpt_reg - 8'h01;                     // [RULE10]
            end
            if (is_long) begin
               long_pend_reg  <= 1'b1;                         // [RULE11]
               long_shift_reg <= is_lrlk ? 4'h0 : shift4;      // [RULE12]
               is_lrlk_reg    <= is_lrlk;
               lrlk_sel_reg   <= reg_sel;
            end
         end else if (long_pend_reg && long_valid) begin
            imm_reg       <= long_sh;                          // [RULE11]
            imm_vld_reg   <= 1'b1;
            long_pend_reg <= 1'b0;
         end
      end
   end

   assign data_addr         = addr_reg;
   assign addr_valid        = addr_vld_reg;
   assign imm_value         = imm_reg;
   assign imm_valid         = imm_vld_reg;
   assign repeat_left       = rpt_reg;
   assign test_control_flag = flag_reg;
   assign aux_reg_pointer   = ptr_reg;
   assign data_page_pointer = page_reg;
   assign index_aux_reg     = ar_reg[0];

   // ==========================================
   // Checks
   sequence s_ind_mem;
      take && mem_ref && indirect;
   endsequence

   // Direct forms must leave the auxiliary registers alone
   sequence s_dir_mem;
      take && mem_ref && !indirect;
   endsequence

   chk_ptr_reload: assert property (s_ind_mem // [RULE4]
      ##0 pointer_reload_bit |=> ptr_reg == $past(next_ptr))
      else $error("pointer not reloaded");

   chk_ptr_hold: assert property (s_ind_mem // [RULE4]
      ##0 !pointer_reload_bit |=> $stable(ptr_reg))
      else $error("pointer changed without reload");

   chk_addr_before: assert property (s_ind_mem // [RULE15]
      |=> data_addr == $past(cur_ar) && addr_valid)
      else $error("address not taken before update");

   chk_inc_one: assert property (s_ind_mem // [RULE1]
      ##0 upd_code == UPD_INC && !pointer_reload_bit
      |=> cur_ar == $past(cur_ar) + 16'h0001)
      else $error("increment by one wrong");

   chk_dec_one: assert property (s_ind_mem // [RULE1]
      ##0 upd_code == UPD_DEC && !pointer_reload_bit
      |=> cur_ar == $past(cur_ar) - 16'h0001)
      else $error("decrement by one wrong");

   chk_step_one: assert property (s_ind_mem // [RULE1]
      ##0 !index_select_bit && !pointer_reload_bit
      |=> cur_ar - $past(cur_ar) inside {16'h0000, 16'h0001, 16'hffff})
      else $error("step larger than one");

   chk_idx_add: assert property (s_ind_mem // [RULE2]
      ##0 upd_code == UPD_XADD && !pointer_reload_bit && ptr_reg != 3'h0
      |=> cur_ar == $past(cur_ar) + index_aux_reg)
      else $error("index add wrong");

   chk_idx_sub: assert property (s_ind_mem // [RULE2]
      ##0 upd_code == UPD_XSUB && !pointer_reload_bit && ptr_reg != 3'h0
      |=> cur_ar == $past(cur_ar) - index_aux_reg)
      else $error("index subtract wrong");

   chk_rsvd_keep: assert property (s_ind_mem // [RULE17]
      ##0 upd_code == UPD_RSVD && !pointer_reload_bit
      |=> $stable(cur_ar))
      else $error("reserved code changed register");

   chk_direct_addr: assert property (s_dir_mem // [RULE14]
      |=> addr_valid && data_addr == {$past(page_reg), $past(dma)}
          && $stable(cur_ar))
      else $error("direct address wrong");

   chk_cmp_flag: assert property (take && aux_compare_op // [RULE6]
      |=> test_control_flag == $past(cmp_res))
      else $error("compare flag wrong");

   chk_mpy_sign: assert property (take && multiply_short_op // [RULE9]
      |=> imm_valid && imm_value[31] == $past(instr_word[12]))
      else $error("multiply constant not signed");

   chk_page_load: assert property (take && page_load_short_op // [RULE8]
      |=> data_page_pointer == $past(instr_word[8:0]))
      else $error("page pointer not loaded");

   chk_rpt_load: assert property (take && repeat_short_op // [RULE10]
      |=> repeat_left == $past(k8))
      else $error("repeat count not loaded");

   chk_long_shift: assert property (long_pend_reg // [RULE12]
      ##0 long_valid && !instr_valid
      |=> imm_valid && imm_value == ($past(long_sh)))
      else $error("long constant wrong");

endmodule // operand_address_generator

// ### tb_top.sv
module tb_top
   import oag_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Signals
   logic        mclk;
   logic        rst;
   logic        instr_valid;
   logic [15:0] instr_word;
   logic        long_valid;
   logic [15:0] long_word;
   logic        long_signed;
   logic [15:0] data_addr;
   logic        addr_valid;
   logic [31:0] imm_value;
   logic        imm_valid;
   logic [7:0]  repeat_left;
   logic        test_control_flag;
   logic [2:0]  aux_reg_pointer;
   logic [8:0]  data_page_pointer;
   logic [15:0] index_aux_reg;
   int          fail_count;
   int          samples_checked;
   int          cycles;

   operand_address_generator #(.W(16)) DUT (
      .mclk              (mclk),
      .rst               (rst),
      .instr_valid       (instr_valid),
      .instr_word        (instr_word),
      .long_valid        (long_valid),
      .long_word         (long_word),
      .long_signed       (long_signed),
      .data_addr         (data_addr),
      .addr_valid        (addr_valid),
      .imm_value         (imm_value),
      .imm_valid         (imm_valid),
      .repeat_left       (repeat_left),
      .test_control_flag (test_control_flag),
      .aux_reg_pointer   (aux_reg_pointer),
      .data_page_pointer (data_page_pointer),
      .index_aux_reg     (index_aux_reg)
   );

   // ==========================================
   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Ceiling well above the roughly 1100 cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         $display("[FAIL] %0t run did not finish", $time);
         conclude();
      end
   end

   // ==========================================
   // Tasks and model
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One gap cycle after each word keeps the valid pulses apart
   task automatic issue(input logic [15:0] w);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word  <= w;
      @(posedge mclk);
      instr_valid <= 1'b0;
      @(negedge mclk);
   endtask

   task automatic long_op(input logic [15:0] op, input logic [15:0] w,
                          input logic sgn);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word  <= op;
      @(posedge mclk);
      instr_valid <= 1'b0;
      long_valid  <= 1'b1;
      long_word   <= w;
      long_signed <= sgn;
      @(posedge mclk);
      long_valid  <= 1'b0;
      @(negedge mclk);
   endtask

   function automatic logic [15:0] rev(input logic [15:0] v);
      logic [15:0] r;
      for (int i = 0; i < 16; i++) r[i] = v[15-i];
      return r;
   endfunction

   function automatic logic [15:0] upd(input int c, input logic [15:0] a,
                                       input logic [15:0] x);
      case (c)
         1: return a - 16'h0001;
         2: return a + 16'h0001;
         4: return rev(rev(a) - rev(x));
         5: return a - x;
         6: return a + x;
         7: return rev(rev(a) + rev(x));
         default: return a;
      endcase
   endfunction

   // ==========================================
   // Main sequence
   initial begin : main
      logic [15:0] a, x, w;
      logic [31:0] v;
      logic [2:0]  n, y;
      logic [8:0]  p;
      logic [6:0]  d;
      logic [7:0]  k;
      logic [12:0] m;
      logic [3:0]  s;
      logic        sg;
      logic        e;
      rst = 1'b1; instr_valid = 1'b0; instr_word = 16'h0000;
      long_valid = 1'b0; long_word = 16'h0000; long_signed = 1'b0;
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      check(data_addr, 32'h0, "address in reset");
      check(aux_reg_pointer, 32'h0, "pointer in reset");
      @(posedge mclk) rst <= 1'b0;
      void'($urandom(32'h2c37711e));
      for (int c = 0; c < 8; c++) repeat (6) begin
         n = 3'($urandom_range(7, 1)); y = 3'($urandom);
         a = 16'($urandom); x = 16'($urandom);
         long_op({5'h1a, 3'h0, 8'h00}, x, 1'b0);
         long_op({5'h1a, n, 8'h00}, a, 1'b0);
         issue(16'h5588 | 16'(n));
         check(aux_reg_pointer, n, "pointer load");
         check(index_aux_reg, x, "index register");
         sg = 1'($urandom);
         issue({8'h08, 1'b1, 3'(c), sg, y});
         check(data_addr, a, "address before update");
         check(addr_valid, 1, "address strobe");
         check(aux_reg_pointer, sg ? y : n, "pointer reload");
         issue(16'h5588 | 16'(n));
         issue(16'h0880);
         w = upd(c, a, x);
         if (c < 3) check(data_addr, w, "step update");
         else if (c == 3) check(data_addr, w, "reserved code");
         else if (c == 5 || c == 6) check(data_addr, w, "index");
         else check(data_addr, w, "reverse carry");
      end
      $display("test indirect update done");
      for (int mode = 0; mode < 4; mode++) for (int i = 0; i < 4; i++) begin
         n = 3'($urandom_range(7, 1));
         x = 16'($urandom);
         a = (i == 0) ? x : 16'($urandom);
         long_op({5'h1a, 3'h0, 8'h00}, x, 1'b0);
         long_op({5'h1a, n, 8'h00}, a, 1'b0);
         issue(16'h5588 | 16'(n));
         issue(16'hce50 | 16'(mode));
         e = (mode == 0) ? (a == x) : (mode == 1) ? (a < x) :
             (mode == 2) ? (a > x) : (a != x);
         check(test_control_flag, e, "compare flag");
      end
      $display("test compare done");
      repeat (8) begin
         p = 9'($urandom); d = 7'($urandom);
         issue({7'h64, p});
         check(data_page_pointer, p, "page load");
         issue({8'h08, 1'b0, d});
         check(data_addr, {p, d}, "direct address");
      end
      $display("test direct done");
      for (int i = 0; i < 8; i++) begin
         k = (i == 0) ? 8'd99 : 8'($urandom);
         n = 3'(i);
         issue({8'hcc, k});
         check(imm_value, k, "add short");
         check(imm_valid, 1, "immediate strobe");
         issue({8'hca, k});
         check(imm_value, k, "load short");
         m = 13'($urandom);
         issue({3'h5, m});
         check(imm_value, {{19{m[12]}}, m}, "multiply short");
         issue({5'h18, n, k});
         issue(16'h5588 | 16'(n));
         issue(16'h0880);
         check(data_addr, k, "register direct load");
         issue({8'h7e, 8'h05});
         issue({8'h7f, 8'h03});
         issue(16'h0880);
         check(data_addr, 16'(k) + 16'h0002, "aux add and sub");
         issue({8'hcb, k});
         check(repeat_left, k, "repeat count");
         issue(16'h0880);
         if (k != 8'h00)
            check(repeat_left, k - 8'h01, "repeat step");
      end
      $display("test short immediate done");
      for (int i = 0; i < 10; i++) begin
         s = (i == 0) ? 4'h2 : 4'($urandom);
         w = (i == 0) ? 16'h4000 : 16'($urandom);
         sg = (i == 0) ? 1'b0 : 1'($urandom);
         long_op({4'hd, s, 8'h02}, w, sg);
         check(imm_valid, 1, "long strobe");
         v = sg ? {{16{w[15]}}, w} : {16'h0, w};
         check(imm_value, v << s, "long shifted");
         long_op({4'hd, s, 8'h01}, w, 1'b0);
         check(imm_value, {16'h0, w} << s, "long load");
      end
      $display("test long immediate done");
      conclude();
   end
endmodule // tb_top
